// ==== rtl/eprs_defines.vh ====
// Constants and rule summary for the encoder pulse rate scaler
`ifndef EPRS_DEFINES_VH
`define EPRS_DEFINES_VH

// Clock rate in kHz
`define EPRS_CLK_KHZ 20000
// Factor units of 0.0001, five decades
`define EPRS_FACTOR_W 17
`define EPRS_FACTOR_MIN 17'h00005
`define EPRS_FACTOR_MAX 17'h1869f
`define EPRS_FACTOR_RST 17'h02710
// Least spacing of output quadrature edges, 1 MHz pulses
`define EPRS_OUT_EDGE_NS 250
`define EPRS_OUT_EDGE_CYC ((`EPRS_OUT_EDGE_NS * `EPRS_CLK_KHZ) / 1000000)
// Least command hold time on a control input
`define EPRS_CTRL_HOLD_US 2000
`define EPRS_CTRL_HOLD_CYC ((`EPRS_CTRL_HOLD_US * `EPRS_CLK_KHZ) / 1000)
// Control function codes, two bits per control input
`define EPRS_FN_NONE 2'h0
`define EPRS_FN_LOCK 2'h1
`define EPRS_FN_REVERSE 2'h2
`define EPRS_FN_FREEZE 2'h3
// Output generator states, one-hot
`define EPRS_GEN_IDLE 2'h1
`define EPRS_GEN_GAP 2'h2

`endif

// ==== rtl/eprs_quad_out.v ====
// Quadrature output stepper with enforced edge spacing
`timescale 1ns/1ns
`default_nettype none
`include "eprs_defines.vh"

module eprs_quad_out #(
	parameter GAP_CYC = `EPRS_OUT_EDGE_CYC
) (
	input wire i_clock,
	input wire i_rst_b,
	input wire i_step_up,
	input wire i_step_dn,
	output wire o_ready,
	output reg o_a,
	output reg o_a_n,
	output reg o_b,
	output reg o_b_n
);
	localparam [1:0] ST_IDLE = `EPRS_GEN_IDLE;
	localparam [1:0] ST_GAP = `EPRS_GEN_GAP;
	localparam [7:0] GAP_LAST = GAP_CYC[7:0] - 8'h01;

	reg [1:0] state;
	reg [7:0] gap;
	reg [1:0] phase;
	wire take;
	wire [1:0] next_phase;

	// Gray sequence 00,10,11,01 forward; A leads B when counting up
	assign take = o_ready & (i_step_up | i_step_dn);
	assign next_phase = i_step_up ? phase + 2'h1 : phase - 2'h1;
	assign o_ready = state[0];

	// Each edge is followed by a full gap, so edges of A and B are
	// never closer than a quarter period: phase never below 90 deg
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= ST_IDLE;
			gap <= 8'h00;
			phase <= 2'h0;
			o_a <= 1'b0;
			o_a_n <= 1'b1;
			o_b <= 1'b0;
			o_b_n <= 1'b1;
		end else begin
			case (state)
			ST_IDLE: begin
				if (take) begin
					phase <= next_phase;
					o_a <= next_phase[0] ^ next_phase[1];
					o_a_n <= ~(next_phase[0] ^ next_phase[1]);
					o_b <= next_phase[1];
					o_b_n <= ~next_phase[1];
					gap <= GAP_LAST;
					state <= (GAP_LAST == 8'h00) ? ST_IDLE : ST_GAP;
				end
			end
			ST_GAP: begin
				if (gap <= 8'h01) begin
					state <= ST_IDLE;
				end
				gap <= gap - 8'h01;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== rtl/eprs_scaler.v ====
// Encoder pulse rate scaler: decode, scale, synthesise A/B/Z
`timescale 1ns/1ns
`default_nettype none
`include "eprs_defines.vh"

module eprs_scaler #(
	parameter CTRL_HOLD_CYC = `EPRS_CTRL_HOLD_CYC,
	parameter PPR_W = 16
) (
	input wire i_clock,
	input wire i_rst_b,
	input wire i_enc_a,
	input wire i_enc_b,
	input wire i_enc_z,
	input wire [3:0] i_ctrl,
	input wire i_quad_mode,
	input wire [`EPRS_FACTOR_W-1:0] i_factor1,
	input wire [`EPRS_FACTOR_W-1:0] i_factor2,
	input wire [3:0] i_ctrl_active_high,
	input wire [7:0] i_ctrl_func,
	input wire [PPR_W-1:0] i_index_ppr,
	input wire i_index_sync,
	output reg o_a,
	output reg o_a_n,
	output reg o_b,
	output reg o_b_n,
	output reg o_z,
	output reg o_z_n,
	output reg o_keypad_lock,
	output reg o_reverse,
	output reg o_freeze,
	output reg [31:0] o_in_count,
	output reg [31:0] o_out_count,
	output reg [31:0] o_remainder
);
	localparam FW = `EPRS_FACTOR_W;
	localparam [15:0] HOLD_LAST = CTRL_HOLD_CYC[15:0] - 16'h0004;

	// Clamp a factor into its five-decade range
	function [FW-1:0] clamp_factor;
		input [FW-1:0] f;
		begin
			if (f < `EPRS_FACTOR_MIN)
				clamp_factor = `EPRS_FACTOR_MIN;
			else if (f > `EPRS_FACTOR_MAX)
				clamp_factor = `EPRS_FACTOR_MAX;
			else
				clamp_factor = f;
		end
	endfunction

	// True when any active control input carries the given function
	function ctrl_has;
		input [7:0] func;
		input [3:0] act;
		input [1:0] code;
		integer k;
		begin
			ctrl_has = 1'b0;
			for (k = 0; k < 4; k = k + 1)
				if (act[k] && func[2*k +: 2] == code)
					ctrl_has = 1'b1;
		end
	endfunction

	// Pin synchronisers; stage one feeds stage two only
	reg [2:0] sync1;
	reg [2:0] sync2;
	reg [2:0] prev;
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			prev <= 3'h0;
		end else begin
			sync1 <= {i_enc_z, i_enc_b, i_enc_a};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// Control pin synchronisers, one process for all four
	reg [3:0] ctrl_s1;
	reg [3:0] ctrl_s2;
	wire [3:0] ctrl_act;
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_s1 <= 4'h0;
			ctrl_s2 <= 4'h0;
		end else begin
			ctrl_s1 <= i_ctrl;
			ctrl_s2 <= ctrl_s1;
		end
	end

	// Polarity and hold filter; each slice owns its own state bit
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ctrl
			reg [15:0] cnt;
			reg act;
			wire lvl;
			assign lvl = ctrl_s2[g] ~^ i_ctrl_active_high[g];
			assign ctrl_act[g] = act;
			// A level must stand nearly the full hold time to count;
			// glitches shorter than that never reach the functions
			always @(posedge i_clock or negedge i_rst_b) begin
				if (!i_rst_b) begin
					act <= 1'b0;
					cnt <= 16'h0000;
				end else begin
					if (lvl == act) begin
						cnt <= 16'h0000;
					end else if (cnt >= HOLD_LAST) begin
						act <= lvl;
						cnt <= 16'h0000;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Input edge decode
	wire a_chg;
	wire b_chg;
	wire in_step;
	wire in_up;
	wire z_rise;
	assign a_chg = sync2[0] ^ prev[0];
	assign b_chg = sync2[1] ^ prev[1];
	assign z_rise = sync2[2] & ~prev[2];
	// Single channel counts both A edges upward; quadrature counts
	// every edge with sign from phase, a double change is dropped
	assign in_step = i_quad_mode ? (a_chg ^ b_chg) : a_chg;
	assign in_up = ~i_quad_mode | (sync2[0] ^ prev[1]);

	// Effective factors, in 0.0001 units
	wire [FW-1:0] f1;
	wire [FW-1:0] f2;
	assign f1 = clamp_factor(i_factor1);
	assign f2 = clamp_factor(i_factor2);

	// Single mode: one input pulse weighs as much as one output
	// pulse's worth of edges needs, so A edges carry double weight
	wire signed [31:0] f1_w;
	wire signed [31:0] f2_s;
	assign f1_w = i_quad_mode ? $signed({15'h0000, f1}) :
		$signed({14'h0000, f1, 1'b0});
	assign f2_s = $signed({15'h0000, f2});

	// Accumulator and output request
	reg signed [31:0] acc;
	wire want_up;
	wire want_dn;
	wire gen_ready;
	reg [15:0] since;
	reg [15:0] frz_int;
	reg frz_up;
	reg [15:0] frz_cnt;
	wire frz_fire;
	wire step_up;
	wire step_dn;
	wire out_take;
	reg signed [31:0] inc;
	reg signed [31:0] dec;
	reg signed [31:0] next_acc;

	assign want_up = acc >= f2_s;
	assign want_dn = acc <= -f2_s;
	assign frz_fire = o_freeze & (frz_int != 16'hffff) &
		(frz_cnt >= frz_int);
	// Logical direction of the output step, before reversal
	assign step_up = o_freeze ? (frz_fire & frz_up) : want_up;
	assign step_dn = o_freeze ? (frz_fire & ~frz_up) : (want_dn & ~want_up);
	assign out_take = gen_ready & (step_up | step_dn);

	// Remainder carried every cycle: input adds f1_w (F1, or twice F1 in single mode), each output step outside freeze
	// takes F2, so the output total tracks input*F1/F2 exactly until steps made during a freeze add to it
	always @* begin
		inc = 32'sh0;
		dec = 32'sh0;
		if (in_step)
			inc = in_up ? f1_w : -f1_w;
		if (out_take && !o_freeze)
			dec = step_up ? f2_s : -f2_s;
		next_acc = acc + inc - dec;
	end

	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc <= 32'sh0;
			o_remainder <= 32'h0;
			o_in_count <= 32'h0;
			o_out_count <= 32'h0;
		end else begin
			acc <= next_acc;
			o_remainder <= next_acc;
			if (in_step)
				o_in_count <= in_up ? o_in_count + 32'h1 :
					o_in_count - 32'h1;
			if (out_take)
				o_out_count <= step_up ? o_out_count + 32'h1 :
					o_out_count - 32'h1;
		end
	end

	// Control functions and freeze rate capture
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_keypad_lock <= 1'b0;
			o_reverse <= 1'b0;
			o_freeze <= 1'b0;
			since <= 16'hffff;
			frz_int <= 16'hffff;
			frz_up <= 1'b1;
			frz_cnt <= 16'h0000;
		end else begin
			o_keypad_lock <= ctrl_has(i_ctrl_func, ctrl_act,
				`EPRS_FN_LOCK);
			o_reverse <= ctrl_has(i_ctrl_func, ctrl_act,
				`EPRS_FN_REVERSE);
			o_freeze <= ctrl_has(i_ctrl_func, ctrl_act,
				`EPRS_FN_FREEZE);
			// Interval between steps saturates; a stopped output
			// freezes to stopped rather than to a stale rate
			if (out_take) begin
				since <= 16'h0000;
				if (!o_freeze) begin
					frz_int <= since;
					frz_up <= step_up;
				end
			end else begin
				if (since != 16'hffff)
					since <= since + 16'h0001;
				// A long silence lowers the rate that a freeze replays
				if (!o_freeze && since > frz_int)
					frz_int <= since;
			end
			if (!o_freeze || out_take)
				frz_cnt <= 16'h0000;
			else if (frz_cnt != 16'hffff)
				frz_cnt <= frz_cnt + 16'h0001;
		end
	end

	// Output stepper; bursts come from backlog draining at full rate
	wire gen_a;
	wire gen_a_n;
	wire gen_b;
	wire gen_b_n;
	eprs_quad_out #(
		.GAP_CYC(`EPRS_OUT_EDGE_CYC)
	) u_quad_out (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_step_up(step_up ^ (o_reverse & (step_up | step_dn))),
		.i_step_dn(step_dn ^ (o_reverse & (step_up | step_dn))),
		.o_ready(gen_ready),
		.o_a(gen_a),
		.o_a_n(gen_a_n),
		.o_b(gen_b),
		.o_b_n(gen_b_n)
	);

	// Index position over output edges, four per pulse
	reg [PPR_W+1:0] pos;
	wire [PPR_W+1:0] pos_last;
	wire idx_on;
	assign pos_last = {i_index_ppr, 2'b00} - {{PPR_W{1'b0}}, 2'b01};
	assign idx_on = (i_index_ppr != {PPR_W{1'b0}});

	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos <= {(PPR_W+2){1'b0}};
		end else if (i_index_sync && z_rise) begin
			pos <= {(PPR_W+2){1'b0}};
		end else if (out_take && idx_on) begin
			if (step_up)
				pos <= (pos >= pos_last) ? {(PPR_W+2){1'b0}} :
					pos + {{PPR_W{1'b0}}, 2'b01};
			else
				pos <= (pos == {(PPR_W+2){1'b0}}) ? pos_last :
					pos - {{PPR_W{1'b0}}, 2'b01};
		end
	end

	// Registered outputs, all six always driven
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_a <= 1'b0;
			o_a_n <= 1'b1;
			o_b <= 1'b0;
			o_b_n <= 1'b1;
			o_z <= 1'b0;
			o_z_n <= 1'b1;
		end else begin
			o_a <= gen_a;
			o_a_n <= gen_a_n;
			o_b <= gen_b;
			o_b_n <= gen_b_n;
			o_z <= idx_on && pos == {(PPR_W+2){1'b0}};
			o_z_n <= ~(idx_on && pos == {(PPR_W+2){1'b0}});
		end
	end
endmodule
`default_nettype wire

// ==== verification/eprs_checker.sv ====
// Port-level assertions for the encoder pulse rate scaler
`timescale 1ns/1ns
`default_nettype none
module eprs_checker (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_quad_mode,
	input wire logic o_a,
	input wire logic o_a_n,
	input wire logic o_b,
	input wire logic o_b_n,
	input wire logic o_z,
	input wire logic o_z_n,
	input wire logic o_freeze,
	input wire logic [31:0] o_in_count,
	input wire logic [31:0] o_out_count
);
// One clock domain, so clock and reset are given once
default clocking cb @(posedge i_clock); endclocking
default disable iff (!i_rst_b);
sequence s_edge; $changed(o_a) || $changed(o_b); endsequence
property p_a_inv; o_a_n == !o_a; endproperty
a_a_inv: assert property (p_a_inv) else $error("A complement wrong");
property p_b_inv; o_b_n == !o_b; endproperty
a_b_inv: assert property (p_b_inv) else $error("B complement wrong");
property p_z_inv; o_z_n != o_z; endproperty
a_z_inv: assert property (p_z_inv) else $error("Z complement wrong");
property p_gap; s_edge |=> ($stable(o_a) && $stable(o_b)) [*4]; endproperty
a_gap: assert property (p_gap) else $error("Output edges too close");
property p_one; !($changed(o_a) && $changed(o_b)); endproperty
a_one: assert property (p_one) else $error("A and B moved together");
property p_in; $changed(o_in_count) |-> o_in_count - $past(o_in_count)
	== 32'h1 || $past(o_in_count) - o_in_count == 32'h1; endproperty
a_in: assert property (p_in) else $error("Input count jumped");
property p_single; !i_quad_mode && $changed(o_in_count) |->
	o_in_count - $past(o_in_count) == 32'h1; endproperty
a_single: assert property (p_single) else $error("Single mode down");
property p_out; $changed(o_out_count) |-> o_out_count - $past(o_out_count)
	== 32'h1 || $past(o_out_count) - o_out_count == 32'h1; endproperty
a_out: assert property (p_out) else $error("Output count jumped");
// Each counted output step outside freeze must reach the pins one cycle later
property p_follow; !o_freeze && $changed(o_out_count) |-> ##1 s_edge;
endproperty
a_follow: assert property (p_follow) else $error("Step not emitted");
property p_rst; $rose(i_rst_b) |-> !o_a && !o_b && o_in_count == 32'h0;
endproperty
a_rst: assert property (p_rst) else $error("Bad state at release");
c_edge: cover property (s_edge);
c_z: cover property ($rose(o_z));
c_single: cover property (!i_quad_mode && $changed(o_in_count));
endmodule
`default_nettype wire

// ==== verification/eprs_enc_model.sv ====
// Encoder stand-in: quadrature A/B/Z pins from step requests
`timescale 1ns/1ns
`default_nettype none
module eprs_enc_model (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_step,
	input wire logic i_dir,
	output logic o_a,
	output logic o_b,
	output logic o_z,
	output logic signed [31:0] o_pos
);
logic [2:0] gap;
// Gray up order 00,10,11,01 taken from the position
assign o_a = o_pos[1] ^ o_pos[0];
assign o_b = o_pos[1];
assign o_z = o_pos[3:0] == 4'h0;
// Steps in the 4 cycles after a taken step are dropped, so pins stay within 1 MHz
always @(posedge i_clock or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_pos <= 32'sh0;
		gap <= 3'h0;
	end else if (i_step && gap == 3'h0) begin
		o_pos <= i_dir ? o_pos - 1 : o_pos + 1;
		gap <= 3'h4;
	end else if (gap != 3'h0) begin
		gap <= gap - 3'h1;
	end
end
endmodule
`default_nettype wire

// ==== verification/eprs_scaler_tb.sv ====
// Self-checking bench for the encoder pulse rate scaler
`timescale 1ns/1ns
`default_nettype none
module eprs_scaler_tb;
localparam int HOLD = 40;
logic clk = 0, rst_b = 0, step = 0, dir = 0, qm = 1, zs = 0;
logic pa = 0, pb = 0, pea = 0, zhi = 0;
logic [3:0] ctrl = 4'hf, pol = 4'h0;
logic [7:0] fn = 8'h00;
logic [16:0] f1 = 17'h02710, f2 = 17'h02710;
logic [15:0] ppr = 16'h0000;
wire a, an, b, bn, z, zn, lk, rv, fz, ea, eb, ez;
wire [31:0] ic, oc, rm;
wire signed [31:0] pos;
int bad_count = 0, check_count = 0, seed = 88553, r;
longint opos = 0, aed = 0;
eprs_scaler #(.CTRL_HOLD_CYC(HOLD)) i_eprs_scaler (.i_clock(clk),
	.i_rst_b(rst_b), .i_enc_a(ea), .i_enc_b(eb), .i_enc_z(ez), .i_ctrl(ctrl),
	.i_quad_mode(qm), .i_factor1(f1), .i_factor2(f2),
	.i_ctrl_active_high(pol), .i_ctrl_func(fn), .i_index_ppr(ppr),
	.i_index_sync(zs), .o_a(a), .o_a_n(an), .o_b(b), .o_b_n(bn), .o_z(z),
	.o_z_n(zn), .o_keypad_lock(lk), .o_reverse(rv), .o_freeze(fz),
	.o_in_count(ic), .o_out_count(oc), .o_remainder(rm));
eprs_enc_model i_eprs_enc_model (.i_clock(clk), .i_rst_b(rst_b),
	.i_step(step), .i_dir(dir), .o_a(ea), .o_b(eb), .o_z(ez), .o_pos(pos));
// 20 MHz clock
initial forever #25 clk = ~clk;
function automatic logic [1:0] gi(input logic x, input logic y);
	return {y, x ^ y};
endfunction
// Own decode of the output pins, independent of the design's counters
always @(posedge clk) begin
	if (!rst_b) begin
		opos <= 0;
		aed <= 0;
		zhi <= 0;
	end else begin
		if (gi(a, b) - gi(pa, pb) == 2'h1)
			opos <= opos + 1;
		if (gi(a, b) - gi(pa, pb) == 2'h3)
			opos <= opos - 1;
		if (ea !== pea)
			aed <= aed + 1;
		zhi <= zhi | z;
	end
	pa <= a;
	pb <= b;
	pea <= ea;
end
task cyc(input int n);
	repeat (n) @(posedge clk);
endtask
task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
	check_count++;
	if (seen !== exp) begin
		bad_count++;
		$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
	end
endtask
task close_out;
	if (bad_count == 0 && check_count > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
// Random walk, with reversals in quadrature mode only; long tail lets any backlog drain
task walk(input int n, input int sp);
	repeat (n) begin
		r = $random(seed);
		step <= 1;
		dir <= qm & r[0];
		cyc(1);
		step <= 0;
		cyc(sp - 1);
	end
	cyc(600);
endtask
function automatic longint cl(input logic [16:0] f);
	return f < 17'h00005 ? 5 : f > 17'h1869f ? 99999 : f;
endfunction
task run(input logic [16:0] x, input logic [16:0] y, input logic q, int n);
	longint i, w;
	logic zx;
	r = $random(seed);
	f1 <= x;
	f2 <= y;
	qm <= q;
	ppr <= {13'h0, r[2:0]};
	zs <= r[3];
	rst_b <= 0;
	cyc(4);
	rst_b <= 1;
	walk(n, 6 + 5 * int'(cl(x) / cl(y)));
	i = $signed(ic);
	w = q ? cl(x) : 2 * cl(x);
	chk("in_count", i, q ? pos : aed);
	chk("out_count", $signed(oc), opos);
	chk("balance", i * w, $signed(oc) * cl(y) + $signed(rm));
	chk("residue", $signed(rm) < cl(y) && $signed(rm) > -cl(y), 1);
	chk("index", zhi, ppr != 0);
	// Without sync the mark sits where the output count is a whole turn
	zx = ppr != 0 && opos % (longint'(ppr) * 4) == 0;
	if (!zs)
		chk("index_pos", z, zx);
endtask
// Short pulses must be ignored, long ones set the chosen function
task ctl(input int k, input int hold);
	logic [1:0] f;
	logic [31:0] c;
	f = 2'(k + 1);
	c = oc;
	r = $random(seed);
	pol <= r[3:0];
	ctrl <= ~r[3:0];
	fn <= {4{f}};
	cyc(HOLD + 8);
	ctrl[k] <= r[k];
	cyc(hold);
	chk("flags", {fz, rv, lk}, hold > HOLD ? 3'h1 << (f - 1) : 3'h0);
	ctrl[k] <= ~r[k];
	cyc(HOLD + 8);
	chk("flags_off", {fz, rv, lk}, 3'h0);
	chk("still", oc, c);
endtask
task rev;
	longint p, c;
	pol <= 4'h1;
	ctrl <= 4'h1;
	fn <= 8'h02;
	cyc(HOLD + 8);
	p = opos;
	c = $signed(oc);
	walk(20, 6);
	chk("reverse", opos - p, c - $signed(oc));
endtask
initial begin
	run(17'h02710, 17'h02710, 1, 40);
	rev;
	for (int k = 0; k < 8; k++)
		ctl(k % 4, k < 4 ? HOLD + 6 : HOLD / 2);
	run(17'h061a8, 17'h02328, 1, 30);
	run(17'h01537, 17'h01000, 0, 40);
	run(17'h00003, 17'h1ffff, 1, 20);
	run(17'h1869f, 17'h0c350, 1, 20);
	repeat (3) begin
		r = $random(seed);
		run(17'(r[13:0]) + 17'h5, 17'h02710 + 17'(r[25:14]), 1, 30);
	end
	close_out;
end
// Hang guard well past the expected run length
initial begin
	cyc(40000);
	bad_count++;
	close_out;
end
endmodule
bind eprs_scaler eprs_checker i_eprs_checker (.i_clock(i_clock),
	.i_rst_b(i_rst_b), .i_quad_mode(i_quad_mode), .o_a(o_a), .o_a_n(o_a_n),
	.o_b(o_b), .o_b_n(o_b_n), .o_z(o_z), .o_z_n(o_z_n), .o_freeze(o_freeze),
	.o_in_count(o_in_count), .o_out_count(o_out_count));
`default_nettype wire
